// ===== cfsc_pkg.sv
package cfsc_pkg;

  // Register port geometry
  localparam int CFSC_ADDR_W = 8;
  localparam int CFSC_PRI_W  = 3;

  // Register byte offsets
  localparam logic [7:0] CFSC_HARD_STAT_OFF  = 8'h00;
  localparam logic [7:0] CFSC_MM_STAT_OFF    = 8'h04;
  localparam logic [7:0] CFSC_BUS_STAT_OFF   = 8'h08;
  localparam logic [7:0] CFSC_USE_STAT_OFF   = 8'h0c;
  localparam logic [7:0] CFSC_MM_ADDR_OFF    = 8'h10;
  localparam logic [7:0] CFSC_BUS_ADDR_OFF   = 8'h14;
  localparam logic [7:0] CFSC_HCTRL_OFF      = 8'h18;
  localparam logic [7:0] CFSC_SYSTEM_CONTROL_OFF    = 8'h1c;
  localparam logic [7:0] CFSC_STATE_OFF      = 8'h20;

  // Hard fault status bits
  localparam int CFSC_HS_VECTOR_READ_FLAG   = 0;
  localparam int CFSC_HS_ESCALATED_FLAG = 1;
  // Memory management status bits
  localparam int CFSC_MS_INSTR  = 0;
  localparam int CFSC_MS_DATA   = 1;
  localparam int CFSC_MS_STACK  = 2;
  localparam int CFSC_MS_UNSTK  = 3;
  // Bus fault status bits
  localparam int CFSC_BS_STACK  = 0;
  localparam int CFSC_BS_UNSTK  = 1;
  localparam int CFSC_BS_PREF   = 2;
  localparam int CFSC_BS_PREC   = 3;
  localparam int CFSC_BS_IMPR   = 4;
  // Usage fault status bits
  localparam int CFSC_US_NO_COPROCESSOR   = 0;
  localparam int CFSC_US_UNDEFINED_INSTRUCTION  = 1;
  localparam int CFSC_US_INVST  = 2;
  localparam int CFSC_US_INVALID_RETURN_VALUE  = 3;
  localparam int CFSC_US_UNAL   = 4;
  localparam int CFSC_US_DIVIDE_BY_ZERO   = 5;
  // Handler control fields
  localparam int CFSC_HC_MM_EN  = 0;
  localparam int CFSC_HC_BUS_EN = 1;
  localparam int CFSC_HC_US_EN  = 2;
  localparam int CFSC_HC_MM_PRI = 8;
  localparam int CFSC_HC_BS_PRI = 12;
  localparam int CFSC_HC_US_PRI = 16;
  localparam logic [31:0] CFSC_HCTRL_RST = 32'h0000_0000;
  // System control fields
  localparam int CFSC_SC_EXIT   = 1;
  localparam int CFSC_SC_DEEP   = 2;
  localparam int CFSC_SC_SEVP   = 4;
  localparam logic [31:0] CFSC_SYSTEM_CONTROL_RST = 32'h0000_0000;
  // State register bits
  localparam int CFSC_ST_LOCK   = 0;
  localparam int CFSC_ST_SLEEP  = 1;
  localparam int CFSC_ST_DEEP   = 2;
  localparam int CFSC_ST_HOLD   = 3;
  localparam int CFSC_ST_EVENT  = 4;

  // Exception return value checks
  localparam logic [27:0] CFSC_RET_TOP = 28'hfff_ffff;
  localparam logic [3:0]  CFSC_RET_HND = 4'h1;
  localparam logic [3:0]  CFSC_RET_TMS = 4'h9;
  localparam logic [3:0]  CFSC_RET_TPS = 4'hd;

  // Fault reports from pipeline and bus, one-cycle pulses
  typedef struct packed {
    logic        vec_bus_err;
    logic        mm_instr;
    logic        mm_data;
    logic        mm_stack;
    logic        mm_unstack;
    logic        non_executable;
    logic        bus_stack;
    logic        bus_unstack;
    logic        bus_prefetch;
    logic        bus_precise;
    logic        bus_imprecise;
    logic        no_coprocessor;
    logic        undefined_instruction;
    logic        bad_isa_select;
    logic        continuation_bad_ret;
    logic        ret_load;
    logic        unaligned_access;
    logic        divide_by_zero;
    logic [31:0] exception_return_value;
    logic [31:0] addr;
  } cfsc_fault_t;

  // Execution context of the core
  typedef struct packed {
    logic in_nmi;
    logic in_hard;
    logic bus_entry;
  } cfsc_ctx_t;

  typedef enum logic [2:0] {
    CFSC_H_NONE, CFSC_H_HARD, CFSC_H_MM, CFSC_H_BUS, CFSC_H_USAGE
  } cfsc_handler_t;

  typedef enum logic {CFSC_RUN, CFSC_SLEEP} cfsc_sleep_t;

  // Accepts only the permitted return encodings
  function automatic logic cfsc_ret_valid(input logic [31:0] v);
    cfsc_ret_valid = (v[31:4] == CFSC_RET_TOP) &&
                     (v[3:0] == CFSC_RET_HND || v[3:0] == CFSC_RET_TMS || v[3:0] == CFSC_RET_TPS);
  endfunction

endpackage

// ===== cfsc_route.sv
`timescale 1ns/1ps
`default_nettype none
module cfsc_route
  import cfsc_pkg::*;
#(
  parameter int PRI_W = CFSC_PRI_W
) (
  // Fault groups
  input  wire logic             hard_i,
  input  wire logic             mm_i,
  input  wire logic             bus_i,
  input  wire logic             bus_stack_i,
  input  wire logic             use_i,
  // Configuration
  input  wire logic [2:0]       en_i,
  input  wire logic [PRI_W-1:0] mm_pri_i,
  input  wire logic [PRI_W-1:0] bus_pri_i,
  input  wire logic [PRI_W-1:0] use_pri_i,
  // Context
  input  wire logic [PRI_W:0]   exec_pri_i,
  input  wire cfsc_ctx_t        ctx_i,
  // Decision
  output cfsc_handler_t         handler_o,
  output logic                  escalated_flag_o,
  output logic                  lockup_o
);

  // A fault escalates when disabled or unable to preempt
  function automatic logic escalates(input logic en, input logic [PRI_W-1:0] pri, input logic [PRI_W:0] cur);
    escalates = !en || ({1'b0, pri} >= cur);
  endfunction

  logic esc_mm;
  logic esc_bus;
  logic esc_use;
  logic need_hard;

  // Escalation of configurable faults
  assign esc_mm    = mm_i && escalates(en_i[0], mm_pri_i, exec_pri_i);       // see RL9 see RL10
  assign esc_bus   = bus_i && escalates(en_i[1], bus_pri_i, exec_pri_i)
                     && !(bus_stack_i && ctx_i.bus_entry && en_i[1]);         // see RL11
  assign esc_use   = use_i && escalates(en_i[2], use_pri_i, exec_pri_i);     // see RL9 see RL10
  assign escalated_flag_o  = esc_mm || esc_bus || esc_use;                            // see RL2
  assign need_hard = hard_i || escalated_flag_o || ((mm_i || bus_i || use_i) && (ctx_i.in_nmi || ctx_i.in_hard));

  // Hard fault in NMI or hard handler locks; otherwise hard preempts all else
  always_comb begin
    lockup_o  = need_hard && (ctx_i.in_nmi || ctx_i.in_hard);                 // see RL14
    handler_o = CFSC_H_NONE;
    if (lockup_o) begin
      handler_o = CFSC_H_NONE;
    end else if (need_hard) begin
      handler_o = CFSC_H_HARD;                                                // see RL12
    end else if (mm_i) begin
      handler_o = CFSC_H_MM;                                                  // see RL3
    end else if (bus_i) begin
      handler_o = CFSC_H_BUS;                                                 // see RL5
    end else if (use_i) begin
      handler_o = CFSC_H_USAGE;                                               // see RL6
    end
  end

endmodule
`default_nettype wire

// ===== cfsc_core.sv
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RL1: Raise faults for bus, internal, protection errors
// RL2: Vector bus error sets vector flag; escalation escalated_flag
// RL3: Memory map mismatches set per-case flags
// RL4: Non-executable fetch flags instruction violation always
// RL5: Bus errors set per-case bus flags
// RL6: Usage errors set per-case usage flags
// RL7: Bad instruction set or continuation return
// RL8: Configurable priority and enable per handler
// RL9: Equal or lower priority fault escalates
// RL10: Disabled handler fault escalates to hard
// RL11: Bus fault entry stacking never escalates while the bus handler is enabled
// RL12: Hard fault preempts all but reset, NMI
// RL13: Capture address for memory and bus faults
// RL14: Hard fault in NMI or hard locks
// RL15: Lockup from NMI left only by reset
// RL16: Sleep stops core; deep stops all clocks
// RL17: Wait-for-interrupt sleeps unless wake pending
// RL18: Wait-for-event tests and clears event bit
// RL19: Event bit set by send-event, hidden
// RL20: Sleep-on-exit sleeps after handler return
// RL21: Wake on exception; mask defers handler
// RL22: Pend wakes from event wait when enabled
// RL23: Only permitted return values are valid
// RL24: Status flags stay until software clears
module cfsc_core
  import cfsc_pkg::*;
#(
  parameter int PRI_W = CFSC_PRI_W
) (
  // Clock and reset
  input  wire logic                   core_clk_i,
  input  wire logic                   reset_i,
  // Register port
  input  wire logic [CFSC_ADDR_W-1:0] reg_addr_i,
  input  wire logic [31:0]            reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output logic      [31:0]            reg_rdata_o,
  // Fault reports and context
  input  wire cfsc_fault_t            fault_i,
  input  wire cfsc_ctx_t              ctx_i,
  input  wire logic [PRI_W:0]         exec_pri_i,
  input  wire logic                   nmi_i,
  // Sleep and wake inputs
  input  wire logic                   wfi_i,
  input  wire logic                   wfe_i,
  input  wire logic                   sev_i,
  input  wire logic                   handler_done_i,
  input  wire logic                   wake_exc_i,
  input  wire logic                   new_pend_i,
  input  wire logic                   primary_interrupt_mask_i,
  input  wire logic                   fault_mask_a_i,
  // Fault handler steering
  output cfsc_handler_t               handler_req_o,
  output logic                        lockup_o,
  output logic                        handler_hold_o,
  // Clock control
  output logic                        proc_clk_en_o,
  output logic                        sys_clk_en_o,
  output logic                        pll_en_o,
  output logic                        flash_en_o
);

  // Elaboration check on priority width
  if (PRI_W < 1 || PRI_W > 4) begin : g_bad_pri
    $error("PRI_W must lie in 1..4");
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and decode

  logic [1:0]    hard_stat_ff;
  logic [3:0]    mm_stat_ff;
  logic [4:0]    bus_stat_ff;
  logic [5:0]    use_stat_ff;
  logic [31:0]   mm_addr_ff;
  logic [31:0]   bus_addr_ff;
  logic [31:0]   hctrl_ff;
  logic [31:0]   system_control_ff;
  logic [31:0]   rdata_ff;
  logic          lock_ff;
  logic          lock_nmi_ff;
  logic          event_ff;
  logic          deep_ff;
  logic          by_wfe_ff;
  logic          hold_ff;
  cfsc_sleep_t   sleep_ff;
  cfsc_handler_t handler_ff;
  cfsc_handler_t route_handler;
  logic          route_escalated_flag;
  logic          route_lock;

  // Write-one-to-clear mask for a status register
  function automatic logic [31:0] w1c(input logic [7:0] off);
    w1c = (reg_wr_i && reg_addr_i == off) ? reg_wdata_i : 32'h0000_0000;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Fault classification

  logic [3:0] mm_set;
  logic [4:0] bus_set;
  logic [5:0] use_set;
  logic [1:0] hard_set;
  logic       inv_ret;
  logic       active;

  // Faults are ignored while the core is locked
  assign active  = !lock_ff;
  assign inv_ret = fault_i.ret_load && !cfsc_ret_valid(fault_i.exception_return_value); // see RL23

  // Per-case status sets
  assign mm_set[CFSC_MS_INSTR]   = fault_i.mm_instr || fault_i.non_executable;    // see RL4 see RL1
  assign mm_set[CFSC_MS_DATA]    = fault_i.mm_data;                               // see RL3
  assign mm_set[CFSC_MS_STACK]   = fault_i.mm_stack;                              // see RL3
  assign mm_set[CFSC_MS_UNSTK]   = fault_i.mm_unstack;                            // see RL3
  assign bus_set[CFSC_BS_STACK]  = fault_i.bus_stack;                             // see RL5
  assign bus_set[CFSC_BS_UNSTK]  = fault_i.bus_unstack;                           // see RL5
  assign bus_set[CFSC_BS_PREF]   = fault_i.bus_prefetch;                          // see RL5 see RL1
  assign bus_set[CFSC_BS_PREC]   = fault_i.bus_precise;                           // see RL5
  assign bus_set[CFSC_BS_IMPR]   = fault_i.bus_imprecise;                         // see RL5
  assign use_set[CFSC_US_NO_COPROCESSOR]   = fault_i.no_coprocessor;                        // see RL6
  assign use_set[CFSC_US_UNDEFINED_INSTRUCTION]  = fault_i.undefined_instruction;                 // see RL6 see RL1
  assign use_set[CFSC_US_INVST]  = fault_i.bad_isa_select || fault_i.continuation_bad_ret; // see RL7
  assign use_set[CFSC_US_INVALID_RETURN_VALUE]  = inv_ret;                                       // see RL6
  assign use_set[CFSC_US_UNAL]   = fault_i.unaligned_access;                      // see RL6
  assign use_set[CFSC_US_DIVIDE_BY_ZERO]   = fault_i.divide_by_zero;                        // see RL6
  assign hard_set[CFSC_HS_VECTOR_READ_FLAG]  = fault_i.vec_bus_err;                           // see RL2
  assign hard_set[CFSC_HS_ESCALATED_FLAG] = route_escalated_flag;                                 // see RL2

  // Routing with escalation
  cfsc_route #(
    .PRI_W (PRI_W)
  ) u_route (
    .hard_i      (active && fault_i.vec_bus_err),
    .mm_i        (active && (|mm_set)),
    .bus_i       (active && (|bus_set)),
    .bus_stack_i (fault_i.bus_stack),
    .use_i       (active && (|use_set)),
    .en_i        (hctrl_ff[CFSC_HC_US_EN:CFSC_HC_MM_EN]),                         // see RL8
    .mm_pri_i    (hctrl_ff[CFSC_HC_MM_PRI +: PRI_W]),                             // see RL8
    .bus_pri_i   (hctrl_ff[CFSC_HC_BS_PRI +: PRI_W]),
    .use_pri_i   (hctrl_ff[CFSC_HC_US_PRI +: PRI_W]),
    .exec_pri_i  (exec_pri_i),
    .ctx_i       (ctx_i),
    .handler_o   (route_handler),
    .escalated_flag_o    (route_escalated_flag),
    .lockup_o    (route_lock)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Status and address registers

  // Sticky flags; a new set wins over a clear in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      hard_stat_ff <= 2'h0;
      mm_stat_ff   <= 4'h0;
      bus_stat_ff  <= 5'h00;
      use_stat_ff  <= 6'h00;
    end else if (active) begin
      hard_stat_ff <= 2'((hard_stat_ff & ~w1c(CFSC_HARD_STAT_OFF)) | hard_set); // see RL24
      mm_stat_ff   <= 4'((mm_stat_ff & ~w1c(CFSC_MM_STAT_OFF)) | mm_set);       // see RL24
      bus_stat_ff  <= 5'((bus_stat_ff & ~w1c(CFSC_BUS_STAT_OFF)) | bus_set);    // see RL24
      use_stat_ff  <= 6'((use_stat_ff & ~w1c(CFSC_USE_STAT_OFF)) | use_set);    // see RL24
    end else begin
      hard_stat_ff <= 2'(hard_stat_ff & ~w1c(CFSC_HARD_STAT_OFF));
      mm_stat_ff   <= 4'(mm_stat_ff & ~w1c(CFSC_MM_STAT_OFF));
      bus_stat_ff  <= 5'(bus_stat_ff & ~w1c(CFSC_BUS_STAT_OFF));
      use_stat_ff  <= 6'(use_stat_ff & ~w1c(CFSC_USE_STAT_OFF));
    end
  end

  // Address of the faulting access; imprecise errors carry none
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      mm_addr_ff  <= 32'h0000_0000;
      bus_addr_ff <= 32'h0000_0000;
    end else if (active) begin
      if (|mm_set) begin
        mm_addr_ff <= fault_i.addr;                                            // see RL13
      end
      if (|bus_set[CFSC_BS_PREC:CFSC_BS_STACK]) begin
        bus_addr_ff <= fault_i.addr;                                           // see RL13
      end
    end
  end

  // Software configuration registers
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      hctrl_ff   <= CFSC_HCTRL_RST;
      system_control_ff <= CFSC_SYSTEM_CONTROL_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == CFSC_HCTRL_OFF) begin
        hctrl_ff <= reg_wdata_i;                                               // see RL8
      end
      if (reg_addr_i == CFSC_SYSTEM_CONTROL_OFF) begin
        system_control_ff <= reg_wdata_i;
      end
    end
  end

  // Read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rdata_ff <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        CFSC_HARD_STAT_OFF: rdata_ff <= {30'h0, hard_stat_ff};
        CFSC_MM_STAT_OFF:   rdata_ff <= {28'h0, mm_stat_ff};
        CFSC_BUS_STAT_OFF:  rdata_ff <= {27'h0, bus_stat_ff};
        CFSC_USE_STAT_OFF:  rdata_ff <= {26'h0, use_stat_ff};
        CFSC_MM_ADDR_OFF:   rdata_ff <= mm_addr_ff;
        CFSC_BUS_ADDR_OFF:  rdata_ff <= bus_addr_ff;
        CFSC_HCTRL_OFF:     rdata_ff <= hctrl_ff;
        CFSC_SYSTEM_CONTROL_OFF:   rdata_ff <= system_control_ff;
        CFSC_STATE_OFF:     rdata_ff <= {28'h0, hold_ff, deep_ff, sleep_ff == CFSC_SLEEP, lock_ff};
        default:            rdata_ff <= 32'h0000_0000;
      endcase
    end else begin
      rdata_ff <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Handler request and lockup

  // One-cycle handler request pulse
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      handler_ff <= CFSC_H_NONE;
    end else begin
      handler_ff <= route_handler;
    end
  end

  // Lockup; a lockup entered from NMI ignores later NMIs
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      lock_ff     <= 1'b0;
      lock_nmi_ff <= 1'b0;
    end else if (!lock_ff && route_lock) begin
      lock_ff     <= 1'b1;                                                     // see RL14
      lock_nmi_ff <= ctx_i.in_nmi;
    end else if (lock_ff && nmi_i && !lock_nmi_ff) begin
      lock_ff     <= 1'b0;                                                     // see RL14 see RL15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep control

  logic set_event;
  logic wake;

  assign set_event = sev_i || (system_control_ff[CFSC_SC_SEVP] && new_pend_i);        // see RL19 see RL22
  assign wake = wake_exc_i || (by_wfe_ff && event_ff);                         // see RL21 see RL22

  // Event bit; hidden from software, a set wins over a clear
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      event_ff <= 1'b0;
    end else if (set_event) begin
      event_ff <= 1'b1;                                                        // see RL19
    end else if (sleep_ff == CFSC_RUN && wfe_i && active) begin
      event_ff <= 1'b0;                                                        // see RL18
    end else if (sleep_ff == CFSC_SLEEP && by_wfe_ff && event_ff) begin
      event_ff <= 1'b0;
    end
  end

  // Sleep state machine
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      sleep_ff  <= CFSC_RUN;
      deep_ff   <= 1'b0;
      by_wfe_ff <= 1'b0;
    end else begin
      case (sleep_ff)
        CFSC_RUN: begin
          if (active && ((wfi_i && !wake_exc_i) ||                             // see RL17
                         (wfe_i && !event_ff) ||                               // see RL18
                         (handler_done_i && system_control_ff[CFSC_SC_EXIT]))) begin  // see RL20
            sleep_ff  <= CFSC_SLEEP;
            deep_ff   <= system_control_ff[CFSC_SC_DEEP];                             // see RL16
            by_wfe_ff <= wfe_i;
          end
        end
        CFSC_SLEEP: begin
          if (wake) begin
            sleep_ff  <= CFSC_RUN;
            deep_ff   <= 1'b0;
            by_wfe_ff <= 1'b0;
          end
        end
        default: begin
          sleep_ff <= CFSC_RUN;
        end
      endcase
    end
  end

  // Handler held back after a wake while the primary mask is set
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      hold_ff <= 1'b0;
    end else if (sleep_ff == CFSC_SLEEP && wake_exc_i && primary_interrupt_mask_i && !fault_mask_a_i) begin
      hold_ff <= 1'b1;                                                         // see RL21
    end else if (!primary_interrupt_mask_i) begin
      hold_ff <= 1'b0;
    end
  end

  // Outputs
  assign reg_rdata_o    = rdata_ff;
  assign handler_req_o  = handler_ff;
  assign lockup_o       = lock_ff;
  assign handler_hold_o = hold_ff;
  assign proc_clk_en_o  = (sleep_ff == CFSC_RUN);                              // see RL16
  assign sys_clk_en_o   = !deep_ff;                                            // see RL16
  assign pll_en_o       = !deep_ff;
  assign flash_en_o     = !deep_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_vector_flag: assert property (active && fault_i.vec_bus_err |=> hard_stat_ff[CFSC_HS_VECTOR_READ_FLAG]) // see RL2
    else $error("vector read flag not set");
  chk_lockup_entry: assert property (active && fault_i.vec_bus_err && (ctx_i.in_nmi || ctx_i.in_hard) // see RL14
    |=> lockup_o && handler_req_o == CFSC_H_NONE)
    else $error("lockup not entered");
  chk_nmi_lock_hold: assert property (lock_ff && lock_nmi_ff && nmi_i |=> lock_ff) // see RL15
    else $error("NMI left lockup from NMI");
  chk_lock_release: assert property (lock_ff && !lock_nmi_ff && nmi_i |=> !lock_ff) // see RL14
    else $error("NMI did not release lockup");
  chk_disabled_escalate: assert property (active && fault_i.undefined_instruction && // see RL10
    !hctrl_ff[CFSC_HC_US_EN] && !ctx_i.in_nmi && !ctx_i.in_hard
    |=> handler_req_o == CFSC_H_HARD && hard_stat_ff[CFSC_HS_ESCALATED_FLAG])
    else $error("disabled fault not escalated");
  chk_wfe_skip: assert property (sleep_ff == CFSC_RUN && active && wfe_i && event_ff && !set_event // see RL18
    |=> !event_ff && proc_clk_en_o)
    else $error("event wait slept with event set");
  chk_wfi_sleep: assert property (sleep_ff == CFSC_RUN && active && wfi_i && !wake_exc_i // see RL17
    |=> !proc_clk_en_o)
    else $error("interrupt wait did not sleep");
  chk_deep_stop: assert property (!proc_clk_en_o && deep_ff |-> !sys_clk_en_o && !pll_en_o && !flash_en_o) // see RL16
    else $error("deep sleep left clocks running");
  chk_sticky_flag: assert property (use_stat_ff[CFSC_US_DIVIDE_BY_ZERO] && !(reg_wr_i && reg_addr_i == CFSC_USE_STAT_OFF // see RL24
    && reg_wdata_i[CFSC_US_DIVIDE_BY_ZERO]) |=> use_stat_ff[CFSC_US_DIVIDE_BY_ZERO])
    else $error("status flag lost");
  chk_bus_addr: assert property (active && fault_i.bus_precise |=> bus_addr_ff == $past(fault_i.addr)) // see RL13
    else $error("bus fault address not captured");
  chk_invalid_ret: assert property (active && inv_ret |=> use_stat_ff[CFSC_US_INVALID_RETURN_VALUE] ##1 // see RL23
    use_stat_ff[CFSC_US_INVALID_RETURN_VALUE] || $past(reg_wr_i))
    else $error("bad return value not flagged");

endmodule
`default_nettype wire

// ===== cfsc_pipe_model.sv
`timescale 1ns/1ps
`default_nettype none
// Pipeline and bus model: turns a fault kind number into a one-cycle report
module cfsc_pipe_model
  import cfsc_pkg::*;
(
  // Clock and command
  input  wire logic        core_clk_i,
  input  wire logic        go_i,
  input  wire logic [4:0]  kind_i,
  input  wire logic [31:0] addr_i,
  // Fault reports
  output cfsc_fault_t      fault_o
);
  // Address is inverted outside a pulse so a stale value never matches
  always_ff @(posedge core_clk_i) begin
    fault_o <= '0;
    fault_o.addr <= ~addr_i;
    if (go_i) begin
      fault_o[81-kind_i] <= 1'b1;
      fault_o.addr <= addr_i;
    end
  end
endmodule
`default_nettype wire

// ===== tb_cfsc_core.sv
`timescale 1ns/1ps
`default_nettype none
module tb_cfsc_core;
  import cfsc_pkg::*;
  logic          core_clk_i = 0, reset_i = 1, wr = 0, rd = 0, go = 0, rd_d = 0;
  logic          wake = 0, primary_interrupt_mask = 0;
  logic [5:0]    cmd = 0;
  logic [3:0]    en;
  logic          lck, hld;
  logic [4:0]    kind = 0;
  logic [7:0]    addr = 0;
  logic [31:0]   wdata = 0, faddr = 0, last = 0, seed = 32'h976ee81c, rdata;
  logic [3:0]    pri = 4'h8;
  cfsc_ctx_t     ctx = '0;
  cfsc_fault_t   flt;
  cfsc_handler_t hreq;
  logic [31:0]   exp_q[$];
  cfsc_handler_t hq[$];
  int            n_fail = 0, cmp_count = 0;
  cfsc_pipe_model pm (.core_clk_i(core_clk_i), .go_i(go), .kind_i(kind), .addr_i(faddr), .fault_o(flt));
  cfsc_core dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .fault_i(flt), .ctx_i(ctx), .exec_pri_i(pri),
    .nmi_i(cmd[0]), .wfi_i(cmd[3]), .wfe_i(cmd[2]), .sev_i(cmd[1]), .handler_done_i(cmd[4]),
    .wake_exc_i(wake), .new_pend_i(cmd[5]), .primary_interrupt_mask_i(primary_interrupt_mask), .fault_mask_a_i(1'b0),
    .handler_req_o(hreq), .lockup_o(lck), .handler_hold_o(hld), .proc_clk_en_o(en[3]),
    .sys_clk_en_o(en[2]), .pll_en_o(en[1]), .flash_en_o(en[0]));
  // Clock of 40 ns
  initial forever #20 core_clk_i = ~core_clk_i;
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i) begin addr <= a; wdata <= d; wr <= 1; end
    @(posedge core_clk_i) wr <= 0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk_i) begin addr <= a; rd <= 1; exp_q.push_back(e); end
    @(posedge core_clk_i) rd <= 0;
  endtask
  // Raises one fault kind at a random address and notes the handler
  task automatic fault(input logic [4:0] k, input cfsc_handler_t h);
    last = xs();
    @(posedge core_clk_i) begin go <= 1; kind <= k; faddr <= last; end
    if (h != CFSC_H_NONE) hq.push_back(h);
    @(posedge core_clk_i) go <= 0;
    repeat (3) @(posedge core_clk_i);
  endtask
  task automatic pulse(input logic [5:0] c);
    @(posedge core_clk_i) cmd <= c;
    @(posedge core_clk_i) cmd <= 0;
    repeat (2) @(posedge core_clk_i);
  endtask
  // Result watcher takes the oldest note whenever a result appears
  always @(posedge core_clk_i) begin
    if (rd_d) chk("rdata", exp_q.pop_front(), rdata);
    if (!reset_i && hreq !== CFSC_H_NONE) chk("handler", {29'h0, hq.pop_front()}, {29'h0, hreq});
    rd_d <= rd;
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge core_clk_i);
    n_fail++;
    final_report();
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge core_clk_i);
    reset_i <= 0;
    rreg(CFSC_HCTRL_OFF, CFSC_HCTRL_RST);
    rreg(CFSC_STATE_OFF, 32'h0);
    rreg(8'h3c, 32'h0);
    fault(5'd12, CFSC_H_HARD);
    rreg(CFSC_USE_STAT_OFF, 32'h2);
    rreg(CFSC_HARD_STAT_OFF, 32'h2);
    wreg(CFSC_USE_STAT_OFF, 32'h2);
    rreg(CFSC_USE_STAT_OFF, 32'h0);
    fault(5'd0, CFSC_H_HARD);
    rreg(CFSC_HARD_STAT_OFF, 32'h3);
    wreg(CFSC_HCTRL_OFF, 32'h0001_3207);
    rreg(CFSC_HCTRL_OFF, 32'h0001_3207);
    for (int k = 1; k < 5; k++) fault(k[4:0], CFSC_H_MM);
    rreg(CFSC_MM_STAT_OFF, 32'hf);
    rreg(CFSC_MM_ADDR_OFF, last);
    wreg(CFSC_MM_STAT_OFF, 32'hf);
    fault(5'd5, CFSC_H_MM);
    rreg(CFSC_MM_STAT_OFF, 32'h1);
    for (int k = 6; k < 11; k++) fault(k[4:0], CFSC_H_BUS);
    rreg(CFSC_BUS_STAT_OFF, 32'h1f);
    for (int k = 11; k < 18; k++) fault(k[4:0], CFSC_H_USAGE);
    rreg(CFSC_USE_STAT_OFF, 32'h3f);
    pri <= 4'h3;
    fault(5'd9, CFSC_H_HARD);
    pri <= 4'h4;
    fault(5'd9, CFSC_H_BUS);
    rreg(CFSC_BUS_ADDR_OFF, last);
    pri <= 4'h3;
    ctx <= 3'b001;
    fault(5'd6, CFSC_H_BUS);
    ctx.in_hard <= 1;
    fault(5'd2, CFSC_H_NONE);
    rreg(CFSC_STATE_OFF, 32'h1);
    chk("lockup", 32'h1, {31'h0, lck});
    pulse(6'h01);
    rreg(CFSC_STATE_OFF, 32'h0);
    ctx <= 3'b100;
    fault(5'd0, CFSC_H_NONE);
    pulse(6'h01);
    rreg(CFSC_STATE_OFF, 32'h1);
    ctx <= '0;
    reset_i <= 1;
    repeat (2) @(posedge core_clk_i);
    reset_i <= 0;
    pulse(6'h02);
    pulse(6'h04);
    rreg(CFSC_STATE_OFF, 32'h0);
    pulse(6'h04);
    rreg(CFSC_STATE_OFF, 32'h2);
    pulse(6'h02);
    rreg(CFSC_STATE_OFF, 32'h0);
    wreg(CFSC_SYSTEM_CONTROL_OFF, 32'h4);
    primary_interrupt_mask <= 1;
    pulse(6'h08);
    rreg(CFSC_STATE_OFF, 32'h6);
    chk("clk_en", 32'h0, {28'h0, en});
    wake <= 1;
    repeat (3) @(posedge core_clk_i);
    rreg(CFSC_STATE_OFF, 32'h8);
    chk("hold", 32'h1, {31'h0, hld});
    primary_interrupt_mask <= 0;
    pulse(6'h08);
    rreg(CFSC_STATE_OFF, 32'h0);
    wake <= 0;
    wreg(CFSC_SYSTEM_CONTROL_OFF, 32'h12);
    pulse(6'h10);
    rreg(CFSC_STATE_OFF, 32'h2);
    wake <= 1;
    rreg(CFSC_STATE_OFF, 32'h0);
    wake <= 0;
    pulse(6'h04);
    rreg(CFSC_STATE_OFF, 32'h2);
    pulse(6'h20);
    rreg(CFSC_STATE_OFF, 32'h0);
    repeat (4) @(posedge core_clk_i);
    final_report();
  end
endmodule
`default_nettype wire
